//--- stmo_chk_assertions.sv
// Checker on the ports of the serial time message output block.
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Checker module.
// ----------------------------------------------------------------
module stmo_chk (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       sys_rst,
  // Settings.
  input wire logic       auto_start,
  // Outputs.
  input wire logic [5:0] field_idx_q,
  input wire logic       tx_pin_q,
  input wire logic       sending
);
  logic [13:0] run_q;  // Cycles the line has held its level.
  logic        last_q; // Line level one cycle ago.
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Count stable cycles so that a short bit slot shows up.
  always @(posedge clk)
  begin
    last_q <= tx_pin_q;
    if (sys_rst || tx_pin_q != last_q)
      run_q <= sys_rst ? 14'h3FFF : 14'h0000;
    else if (run_q != 14'h3FFF)
      run_q <= run_q + 14'h0001;
  end
  auto_send_a: assert property
    ($fell(sys_rst) && auto_start |-> ##[0:4] sending)
    else $error("autostart did not begin a message");
  no_cmd_a: assert property
    ($fell(sys_rst) && !auto_start |-> !sending [*8])
    else $error("message began without start");
  quiet_idle_a: assert property
    (!sending && !$past(sending) |-> tx_pin_q)
    else $error("line left idle while not sending");
  start_bit_a: assert property
    ($rose(sending) |-> ##[0:40] !tx_pin_q)
    else $error("no start bit after message began");
  bit_len_a: assert property
    ($changed(tx_pin_q) |-> run_q >= 14'h0420)
    else $error("bit slot too short");
  idx_range_a: assert property
    (field_idx_q <= 6'h20)
    else $error("field index beyond message");
  idx_step_a: assert property
    ($changed(field_idx_q) |->
      field_idx_q == $past(field_idx_q) + 6'h01 || field_idx_q == 6'h00)
    else $error("field index skipped");
  idx_busy_a: assert property
    ($changed(field_idx_q) |-> sending)
    else $error("field index moved while idle");
endmodule // stmo_chk
bind stmo_top stmo_chk chk_u (.clk(clk), .sys_rst(sys_rst),
  .auto_start(auto_start), .field_idx_q(field_idx_q),
  .tx_pin_q(tx_pin_q), .sending(sending));
`default_nettype wire

//--- stmo_fifo.v
// Character FIFO and the top of the serial time message output block.
`timescale 1ns/1ps
`default_nettype none
`include "stmo_regs.vh"

// ---------------------------------------------------------------------------
// Synchronous FIFO with valid/ready on both sides.
// ---------------------------------------------------------------------------
module stmo_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // Clock and reset.
  input  wire             clk,
  input  wire             sys_rst,
  // Fill side.
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side.
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words.
  reg [AW:0]      wp_q;            // Write pointer with wrap bit.
  reg [AW:0]      rp_q;            // Read pointer with wrap bit.
  wire            full;
  wire            empty;

  // Full when pointers differ only in the wrap bit.
  assign full      = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign empty     = (wp_q == rp_q);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rp_q[AW-1:0]];

  // Pointer and storage update.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (in_valid && !full)
      begin
        mem[wp_q[AW-1:0]] <= in_data;
        wp_q <= wp_q + 1'b1;
      end
      if (out_ready && !empty)
        rp_q <= rp_q + 1'b1;
    end
  end
endmodule // stmo_fifo

// ---------------------------------------------------------------------------
// Serial time message output.
// Overview of operation
// RULE1 - Autostart sends message every second unprompted.
// RULE2 - C or c starts per-second messages.
// RULE3 - R or r halts messages until restarted; the code keeps sending each second while auto_start is set.
// RULE4 - Parity odd, none or even frames characters.
// RULE5 - Each message ends with one quality character.
// RULE6 - Space when time valid, X when invalid.
// RULE7 - Holdover appends chosen X, space or F.
// RULE8 - Holdover means clock runs on own oscillator.
// RULE9 - Setting changes apply at next message boundary.
// ---------------------------------------------------------------------------
module stmo_top (
  // Clock and reset.
  input  wire        clk,
  input  wire        sys_rst,
  // Settings.
  input  wire        auto_start,
  input  wire [1:0]  parity_sel,
  input  wire [1:0]  holdover_sel,
  // Clock state.
  input  wire        time_valid,
  input  wire        holdover,
  // Time field characters, one per index, presented by the time source.
  output reg  [5:0]  field_idx_q,
  input  wire [7:0]  field_char,
  // Serial pins.
  input  wire        rx_pin,
  output reg         tx_pin_q,
  // Status.
  output wire        sending
);
  // Receiver sync and framing.
  reg        rx_s1_q;             // First synchroniser stage.
  reg        rx_s2_q;             // Second synchroniser stage.
  reg [15:0] rx_cnt_q;            // Bit timer.
  reg [3:0]  rx_bit_q;            // Bit position.
  reg [7:0]  rx_sh_q;             // Shift register.
  reg        rx_busy_q;           // Receiving a character.
  reg        run_q;               // Messages enabled by command.
  // Per-second pacing and message builder.
  reg [26:0] sec_q;               // Second counter.
  reg        bld_q;               // Building a message.
  reg [1:0]  par_lat_q;           // Parity latched at message start.
  reg [1:0]  hq_lat_q;            // Holdover choice latched.
  wire       push_v;
  wire       push_rdy;
  wire [7:0] push_d;
  wire       last_field;
  // Transmitter.
  wire       pop_v;
  wire [7:0] pop_d;
  reg        pop_r;
  reg [10:0] tx_sh_q;             // Outgoing frame bits.
  reg [3:0]  tx_left_q;           // Bits left in frame.
  reg [15:0] tx_cnt_q;            // Bit timer.
  reg [1:0]  tx_par_q;            // Parity used for current message.

  // Quality character from clock state and holdover choice.
  function [7:0] qual_char;
    input       valid;
    input       hold;
    input [1:0] sel;
    begin
      if (hold) // RULE7 RULE8
        qual_char = (sel == `STMO_HQ_SPACE) ? `STMO_CH_SPACE :
                    (sel == `STMO_HQ_F) ? `STMO_CH_F : `STMO_CH_X;
      else
        qual_char = valid ? `STMO_CH_SPACE : `STMO_CH_X; // RULE6
    end
  endfunction

  // ---------------------------------------------------------------------
  // Command receiver.
  // ---------------------------------------------------------------------
  // Commands are read as 8N1; any parity bit lands in the stop slot harmlessly.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      rx_s1_q   <= 1'b1;
      rx_s2_q   <= 1'b1;
      rx_cnt_q  <= 16'h0000;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 8'h00;
      rx_busy_q <= 1'b0;
      run_q     <= 1'b0;
    end
    else
    begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
      if (!rx_busy_q)
      begin
        // Start bit: wait half a bit to sample mid-cell.
        if (!rx_s2_q)
        begin
          rx_busy_q <= 1'b1;
          rx_cnt_q  <= `STMO_BIT_HALF;
          rx_bit_q  <= 4'h0;
        end
      end
      else if (rx_cnt_q != 16'h0000)
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      else
      begin
        rx_cnt_q <= `STMO_BIT_LAST;
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0 && rx_s2_q)
          rx_busy_q <= 1'b0; // False start.
        else if (rx_bit_q >= 4'h1 && rx_bit_q <= 4'h8)
          rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
        else if (rx_bit_q == 4'h9)
        begin
          rx_busy_q <= 1'b0;
          if (rx_sh_q == `STMO_CH_C_UP || rx_sh_q == `STMO_CH_C_LO)
            run_q <= 1'b1; // RULE2
          else if (rx_sh_q == `STMO_CH_R_UP || rx_sh_q == `STMO_CH_R_LO)
            run_q <= 1'b0; // RULE3
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // Message builder, paced once per second.
  // ---------------------------------------------------------------------
  assign last_field = (field_idx_q == `STMO_FIELD_LEN);
  assign push_v     = bld_q;
  // Fields first, then exactly one quality character.
  assign push_d     = last_field ? qual_char(time_valid, holdover, hq_lat_q)
                                 : field_char; // RULE5
  assign sending    = bld_q || pop_v || (tx_left_q != 4'h0);

  // Second tick starts a message if enabled; a busy builder skips the tick.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      sec_q       <= 27'h0000000;
      bld_q       <= 1'b0;
      field_idx_q <= 6'h00;
      par_lat_q   <= `STMO_PAR_NONE;
      hq_lat_q    <= `STMO_HQ_X;
    end
    else
    begin
      if (sec_q == `STMO_SEC_LAST)
        sec_q <= 27'h0000000;
      else
        sec_q <= sec_q + 27'h0000001;
      if (!bld_q)
      begin
        // Start mode is sampled at the tick itself, a message boundary.
        if (sec_q == 27'h0000000 && (auto_start || run_q)) // RULE1 RULE9
        begin
          bld_q       <= 1'b1;
          field_idx_q <= 6'h00;
          par_lat_q   <= parity_sel;   // RULE9
          hq_lat_q    <= holdover_sel; // RULE9
        end
      end
      else if (push_rdy)
      begin
        if (last_field)
          bld_q <= 1'b0;
        else
          field_idx_q <= field_idx_q + 6'h01;
      end
    end
  end

  stmo_fifo #(
    .WIDTH (8),
    .DEPTH (`STMO_FIFO_DEPTH),
    .AW    (5)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (push_v),
    .in_ready  (push_rdy),
    .in_data   (push_d),
    .out_valid (pop_v),
    .out_ready (pop_r),
    .out_data  (pop_d)
  );

  // ---------------------------------------------------------------------
  // Transmitter.
  // ---------------------------------------------------------------------
  // Take a character only when the line is idle.
  always @*
  begin
    pop_r = pop_v && (tx_left_q == 4'h0);
  end

  // Frame: start, 8 data LSB first, optional parity, stop.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      tx_pin_q  <= 1'b1;
      tx_sh_q   <= 11'h7FF;
      tx_left_q <= 4'h0;
      tx_cnt_q  <= 16'h0000;
      tx_par_q  <= `STMO_PAR_NONE;
    end
    else if (tx_left_q == 4'h0)
    begin
      tx_pin_q <= 1'b1;
      // Reload only while nothing waits, so a message never mixes parity.
      if (!pop_v)
        tx_par_q <= par_lat_q; // RULE9
      if (pop_v)
      begin
        tx_cnt_q <= `STMO_BIT_LAST;
        if (tx_par_q == `STMO_PAR_NONE) // RULE4
        begin
          tx_sh_q   <= {2'h3, pop_d, 1'b0};
          tx_left_q <= 4'hA;
        end
        else
        begin
          tx_sh_q   <= {1'b1, (^pop_d) ^ (tx_par_q == `STMO_PAR_ODD),
                        pop_d, 1'b0}; // RULE4
          tx_left_q <= 4'hB;
        end
      end
    end
    else if (tx_cnt_q == `STMO_BIT_LAST)
    begin
      tx_pin_q <= tx_sh_q[0];
      tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
      tx_cnt_q <= 16'h0000;
    end
    else if (tx_cnt_q == `STMO_BIT_PRE)
    begin
      tx_cnt_q  <= tx_cnt_q + 16'h0001;
      tx_left_q <= tx_left_q - 4'h1;
    end
    else
      tx_cnt_q <= tx_cnt_q + 16'h0001;
  end
endmodule // stmo_top
`default_nettype wire

//--- stmo_host_model.sv
// Model of the attached computer on the serial time port.
`timescale 1ns/1ps
`default_nettype none
`include "stmo_regs.vh"
// ----------------------------------------------------------------
// Host model.
// ----------------------------------------------------------------
module stmo_host (
  input  wire logic clk,      // System clock.
  input  wire logic tx_pin_q, // Serial line from the block.
  output var  logic rx_pin    // Command line to the block.
);
  // Between commands the line rests at the idle mark.
  initial rx_pin = 1'b1;
  // Send one 8N1 command character, changing the line after an edge.
  task automatic send(input logic [7:0] ch);
    int i;
    begin
      @(posedge clk);
      #1 rx_pin = 1'b0;
      for (i = 0; i < 8; i++)
      begin
        repeat (`STMO_BIT_CYC) @(posedge clk);
        #1 rx_pin = ch[i];
      end
      repeat (`STMO_BIT_CYC) @(posedge clk);
      #1 rx_pin = 1'b1;
      repeat (`STMO_BIT_CYC) @(posedge clk);
    end
  endtask
  // Wait for a start bit, then sample n bits mid-slot, LSB first.
  task automatic recv(input int n, output logic [8:0] v);
    int i;
    begin
      v = 9'h000;
      wait (tx_pin_q === 1'b0);
      repeat (`STMO_BIT_CYC / 2) @(posedge clk);
      for (i = 0; i < n; i++)
      begin
        repeat (`STMO_BIT_CYC) @(posedge clk);
        v[i] = tx_pin_q;
      end
    end
  endtask
endmodule // stmo_host
`default_nettype wire

//--- stmo_regs.vh
// Constants for the serial time message output block.
`ifndef STMO_REGS_VH
`define STMO_REGS_VH
// Clock and serial timing.
`define STMO_CLK_HZ        125000000
`define STMO_BAUD          115200
`define STMO_BIT_CYC       (`STMO_CLK_HZ / `STMO_BAUD)
`define STMO_SEC_CYC       `STMO_CLK_HZ
// Sized timer end points; they must follow the clock and baud above.
`define STMO_BIT_HALF      16'h021E
`define STMO_BIT_LAST      16'h043C
`define STMO_BIT_PRE       16'h043B
`define STMO_SEC_LAST      27'h773593F
// Character codes.
`define STMO_CH_C_UP       8'h43
`define STMO_CH_C_LO       8'h63
`define STMO_CH_R_UP       8'h52
`define STMO_CH_R_LO       8'h72
`define STMO_CH_SPACE      8'h20
`define STMO_CH_X          8'h58
`define STMO_CH_F          8'h46
// Parity selections.
`define STMO_PAR_NONE      2'h0
`define STMO_PAR_ODD       2'h1
`define STMO_PAR_EVEN      2'h2
// Holdover quality selections.
`define STMO_HQ_X          2'h0
`define STMO_HQ_SPACE      2'h1
`define STMO_HQ_F          2'h2
// Message layout.
`define STMO_FIELD_LEN     6'h20
`define STMO_FIFO_DEPTH    32
`endif

//--- tb_top.sv
// Testbench for the serial time message output block.
`timescale 1ns/1ps
`default_nettype none
`include "stmo_regs.vh"
module tb_top;
  logic       clk, sys_rst, auto_start, time_valid, holdover;
  logic       rx_pin, tx_pin_q, sending;
  logic [1:0] parity_sel, holdover_sel;
  logic [5:0] field_idx_q;
  logic [7:0] field_char;
  logic [8:0] got;
  int         bad_count, n_checks;
  // Time source: a distinct digit-like character for each index.
  assign field_char = {2'h0, field_idx_q} + 8'h30;
  stmo_top dut_u (.clk(clk), .sys_rst(sys_rst), .auto_start(auto_start),
    .parity_sel(parity_sel), .holdover_sel(holdover_sel),
    .time_valid(time_valid), .holdover(holdover),
    .field_idx_q(field_idx_q), .field_char(field_char),
    .rx_pin(rx_pin), .tx_pin_q(tx_pin_q), .sending(sending));
  stmo_host host_u (.clk(clk), .tx_pin_q(tx_pin_q), .rx_pin(rx_pin));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Compare one value and count the outcome.
  task automatic check(input string what, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Hold reset for three cycles with the chosen start mode.
  task automatic do_reset(input logic auto);
    @(posedge clk);
    #1 sys_rst = 1'b1;
    auto_start = auto;
    repeat (3) @(posedge clk);
    #1 sys_rst = 1'b0;
  endtask
  // Without autostart and with no command the port stays silent.
  task automatic t_quiet;
    do_reset(1'b0);
    check("reset idx", {2'h0, field_idx_q}, 8'h00);
    repeat (2000) @(posedge clk);
    #1 check("quiet sending", {7'h0, sending}, 8'h00);
    check("quiet line", {7'h0, tx_pin_q}, 8'h01);
    $display("test quiet done");
  endtask
  // Start and halt characters set and clear the command run state.
  task automatic t_cmd;
    do_reset(1'b0);
    host_u.send(`STMO_CH_C_LO);
    #1 check("run after c", {7'h0, dut_u.run_q}, 8'h01);
    host_u.send(`STMO_CH_R_UP);
    #1 check("run after R", {7'h0, dut_u.run_q}, 8'h00);
    host_u.send(`STMO_CH_C_UP);
    #1 check("run after C", {7'h0, dut_u.run_q}, 8'h01);
    host_u.send(`STMO_CH_R_LO);
    #1 check("run after r", {7'h0, dut_u.run_q}, 8'h00);
    $display("test cmd done");
  endtask
  // Autostart sends the first field character with even parity.
  task automatic t_auto;
    parity_sel = `STMO_PAR_EVEN;
    do_reset(1'b1);
    repeat (5) @(posedge clk);
    #1 check("auto sending", {7'h0, sending}, 8'h01);
    host_u.recv(9, got);
    check("first char", got[7:0], 8'h30);
    check("parity bit", {7'h0, got[8]}, 8'h00);
    $display("test auto done");
  endtask
  initial
  begin
    sys_rst = 1'b1;
    auto_start = 1'b0;
    parity_sel = `STMO_PAR_NONE;
    holdover_sel = `STMO_HQ_X;
    time_valid = 1'b1;
    holdover = 1'b0;
    bad_count = 0;
    n_checks = 0;
    t_quiet();
    t_cmd();
    t_auto();
    tally_and_finish();
  end
  // Cut a hang short well after all three tests should have ended.
  initial
  begin
    repeat (80000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
